// ---- src/ssl_map.svh ----
// Register offsets, field positions, reset values and timing counts of the supply supervisor block
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH

// Byte addresses of the control and status words
`define SSL_HCTL_ADDR   12'h000
`define SSL_LCTL_ADDR   12'h004
`define SSL_FLAG_ADDR   12'h008
`define SSL_MODE_ADDR   12'h00C
// Word indices of the prolongation key and control words; byte address is four times these
`define SSL_KEY_IDX     12'h110
`define SSL_PROL_IDX    12'h112

// Fields shared by both side control words
`define SSL_SUP_EN      0
`define SSL_SUP_KEEP    1
`define SSL_SUP_FP      2
`define SSL_MON_EN      3
`define SSL_MON_FP      4
`define SSL_AUTO        5
`define SSL_SIDE_OPT    6
`define SSL_CTL_W       7

// Flag word fields
`define SSL_FLG_LDLY    0
`define SSL_FLG_HDLY    1
`define SSL_FLG_LSUP    2
`define SSL_FLG_LMON    3
`define SSL_FLG_HOVP    4

// Mode word fields
`define SSL_MODE_ENTER  0
`define SSL_MODE_DEEP   1
`define SSL_MODE_AUTO   2
`define SSL_MODE_STATE  4
`define SSL_MODE_SLOW   8

// Prolongation key and enable mask
`define SSL_PROL_KEY    16'h9602
`define SSL_PROL_BIT    11

// Reset values: both supervisors on in normal mode, monitors off
`define SSL_HCTL_RST    7'h01
`define SSL_LCTL_RST    7'h01
`define SSL_MODE_RST    2'h0

// Timing, times in ns and clock rate in MHz
`define SSL_CLK_MHZ     125
`define SSL_FAST_NS     2000
`define SSL_SLOW_NS     150000
`define SSL_GUARD_NS    1000
`define SSL_FAST_CYC    ((`SSL_FAST_NS * `SSL_CLK_MHZ + 999) / 1000)
`define SSL_SLOW_CYC    ((`SSL_SLOW_NS * `SSL_CLK_MHZ + 999) / 1000)
`define SSL_GUARD_CYC   ((`SSL_GUARD_NS * `SSL_CLK_MHZ + 999) / 1000)

`endif

// ---- src/ssl_pkg.sv ----
// Types of the supply supervisor block
package ssl_pkg;
  typedef enum logic [1:0] {ssl_off = 2'h0, ssl_norm = 2'h1, ssl_full = 2'h2} ssl_unit_t;
  typedef enum logic [3:0] {
    pm_active = 4'h1,
    pm_light  = 4'h2,
    pm_deep   = 4'h4,
    pm_wake   = 4'h8
  } ssl_pmode_t;
endpackage : ssl_pkg

// ---- src/ssl_settle_timer.sv ----
// One-shot delay counter with a short and a long length
`timescale 1ns/1ps
`default_nettype none
module ssl_settle_timer #(
  parameter int unsigned FAST_CYC = 250,
  parameter int unsigned SLOW_CYC = 18750
) (
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst,
  // Control
  input  wire logic  start,
  input  wire logic  slow_sel,
  // Status
  output logic       busy
);
  localparam int W = $clog2(SLOW_CYC + 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         busy_reg;
  logic         busy_next;

  // A start reloads the count, even while already running
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (start) begin
      cnt_next  = slow_sel ? W'(SLOW_CYC - 1) : W'(FAST_CYC - 1);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  // Counter registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;
endmodule : ssl_settle_timer
`default_nettype wire

// ---- src/ssl_side_if.sv ----
// Settings and resulting unit states of one supply side
`timescale 1ns/1ps
`default_nettype none
interface ssl_side_if;
  logic                sup_en;
  logic                sup_keep;
  logic                sup_fp;
  logic                mon_en;
  logic                mon_fp;
  logic                auto_ctrl;
  logic                deep;
  ssl_pkg::ssl_unit_t  sup_state;
  ssl_pkg::ssl_unit_t  mon_state;
  modport cfg (output sup_en, sup_keep, sup_fp, mon_en, mon_fp, auto_ctrl, deep, input sup_state, mon_state);
  modport map (input sup_en, sup_keep, sup_fp, mon_en, mon_fp, auto_ctrl, deep, output sup_state, mon_state);
endinterface : ssl_side_if
`default_nettype wire

// ---- src/ssl_state_map.sv ----
// Maps one side's control bits and the power mode onto supervisor and monitor states
`timescale 1ns/1ps
`default_nettype none
module ssl_state_map #(
  parameter bit HIGH_SIDE = 1'b0
) (
  // Side settings in, states out
  ssl_side_if.map side
);
  import ssl_pkg::*;

  // Supervisor state from enable, keep, full performance and automatic control
  always_comb begin
    if (!side.sup_en) begin
      side.sup_state = ssl_off;                                         // [RQ1] [RQ4]
    end else if (!side.deep) begin
      side.sup_state = side.sup_fp ? ssl_full : ssl_norm;               // [RQ1] [RQ4]
    end else if (side.auto_ctrl) begin
      side.sup_state = (side.sup_keep && side.sup_fp) ? ssl_norm : ssl_off; // [RQ2] [RQ4]
    end else if (side.sup_keep) begin
      side.sup_state = side.sup_fp ? ssl_full : ssl_norm;               // [RQ1]
    end else begin
      side.sup_state = ssl_off;                                         // [RQ1] [RQ5]
    end
  end

  // Monitor state; the high side monitor sleeps in deep mode under automatic control
  always_comb begin
    if (!side.mon_en) begin
      side.mon_state = ssl_off;                                         // [RQ3] [RQ4]
    end else if (!side.deep) begin
      side.mon_state = side.mon_fp ? ssl_full : ssl_norm;               // [RQ3] [RQ4]
    end else if (side.auto_ctrl) begin
      side.mon_state = (!HIGH_SIDE && side.mon_fp) ? ssl_norm : ssl_off; // [RQ3] [RQ14]
    end else if (HIGH_SIDE && !side.mon_fp && !side.sup_keep) begin
      side.mon_state = ssl_off;                                         // [RQ5]
    end else begin
      side.mon_state = side.mon_fp ? ssl_full : ssl_norm;               // [RQ3]
    end
  end
endmodule : ssl_state_map
`default_nettype wire

// ---- src/ssl_top.sv ----
// Supply supervisor control with low-power mode sequencing and APB registers
// What this block does
// RQ1 - Low supervisor off when disabled; normal or full by full-perf bit; deep state needs keep bit.
// RQ2 - Automatic low control: deep supervisor runs normal only if enabled, keep and full-perf set.
// RQ3 - Low monitor follows its bits; deep: off/normal/full manual, off/off/normal automatic.
// RQ4 - High supervisor uses the same state mapping as the low side; the high monitor does so outside deep mode.
// RQ5 - High units in normal mode with keep clear switch off entering deep modes.
// RQ6 - Deep wakeup is slow, about 150 us, when low supervisor or monitor is enabled in normal performance; else fast.
// RQ7 - Low supervisor or monitor enabled in normal performance selects slow wakeup.
// RQ8 - Software waits for both settling flags to clear before entering a deep mode.
// RQ9 - Low-power entry by software request or automatically on interrupt routine return.
// RQ10 - Interrupt within 1 us of deep entry still wakes; power-up-clear reset restores operation.
// RQ11 - Software writes key 0x9602 to word 0x0110, then mask 0x0800 to word 0x0112.
// RQ12 - Brown-out reset disables prolongation until software enables it again.
// RQ13 - With overvoltage enable set, a high monitor trip requests a power-on reset.
// RQ14 - Under automatic high control the high monitor is off in every deep mode.
// RQ15 - Low supervisor or monitor events raise reset or interrupt as configured.
// RQ16 - Settling delay masks comparator events: about 2 us full, 150 us normal.
// RQ17 - Settling flag sets on control write and clears when the delay has run out.
`include "ssl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ssl_top #(
  parameter int unsigned SLOW_CYC = `SSL_SLOW_CYC
) (
  // Clock and brown-out reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // APB slave
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Asynchronous pins
  input  wire logic                 power_up_clear_reset,
  input  wire logic                 irq_pending,
  input  wire logic                 low_sup_trip,
  input  wire logic                 low_mon_trip,
  input  wire logic                 high_mon_trip,
  // Core-side request
  input  wire logic                 isr_return,
  // Power mode and unit states
  output ssl_pkg::ssl_pmode_t       power_mode,
  output ssl_pkg::ssl_unit_t        low_sup_state,
  output ssl_pkg::ssl_unit_t        low_mon_state,
  output ssl_pkg::ssl_unit_t        high_sup_state,
  output ssl_pkg::ssl_unit_t        high_mon_state,
  output logic                      wake_slow,
  output logic                      cpu_hold,
  // Events and status
  output logic                      por_request,
  output logic                      low_event_irq,
  output logic                      prolong_enable,
  output logic                      low_delay_flag,
  output logic                      high_delay_flag
);
  import ssl_pkg::*;

  localparam int unsigned FAST_CYC  = `SSL_FAST_CYC;
  localparam int unsigned GUARD_CYC = `SSL_GUARD_CYC;

  // Decodes an address into one-hot word selects
  function automatic logic [5:0] word_sel(input logic [11:0] a);
    word_sel = {a == {`SSL_PROL_IDX, 2'b00}, a == {`SSL_KEY_IDX, 2'b00}, a == `SSL_MODE_ADDR,
                a == `SSL_FLAG_ADDR, a == `SSL_LCTL_ADDR, a == `SSL_HCTL_ADDR};
  endfunction : word_sel

  // Two-flop synchronisers for the pins
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
    end else begin
      pin_s1_reg <= {power_up_clear_reset, irq_pending, low_sup_trip, low_mon_trip, high_mon_trip};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic puc_s, irq_s, lsup_s, lmon_s, hmon_s;
  assign {puc_s, irq_s, lsup_s, lmon_s, hmon_s} = pin_s2_reg;

  // Register state
  logic [`SSL_CTL_W-1:0] hctl_reg, hctl_next, lctl_reg, lctl_next;
  logic [2:0]            ev_reg, ev_next, ev_set;
  logic [1:0]            mode_ctl_reg, mode_ctl_next;
  logic                  key_armed_reg, key_armed_next;
  logic                  prolong_reg, prolong_next;
  logic [31:0]           prdata_reg, prdata_next;
  logic                  pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic                  enter_req, low_start, high_start;
  logic                  low_busy, high_busy, wake_busy;
  logic [5:0]            rsel, wsel;
  logic                  wr;

  // Mode sequencer state
  ssl_pmode_t            mode_reg, mode_next;
  logic [6:0]            guard_reg, guard_next;
  logic                  irq_latch_reg, irq_latch_next;
  logic                  wake_start, wake_slow_next;

  // Side mapping
  ssl_side_if lside ();
  ssl_side_if hside ();
  assign lside.sup_en    = lctl_reg[`SSL_SUP_EN];
  assign lside.sup_keep  = lctl_reg[`SSL_SUP_KEEP];
  assign lside.sup_fp    = lctl_reg[`SSL_SUP_FP];
  assign lside.mon_en    = lctl_reg[`SSL_MON_EN];
  assign lside.mon_fp    = lctl_reg[`SSL_MON_FP];
  assign lside.auto_ctrl = lctl_reg[`SSL_AUTO];
  assign lside.deep      = (mode_reg == pm_deep);
  assign hside.sup_en    = hctl_reg[`SSL_SUP_EN];
  assign hside.sup_keep  = hctl_reg[`SSL_SUP_KEEP];
  assign hside.sup_fp    = hctl_reg[`SSL_SUP_FP];
  assign hside.mon_en    = hctl_reg[`SSL_MON_EN];
  assign hside.mon_fp    = hctl_reg[`SSL_MON_FP];
  assign hside.auto_ctrl = hctl_reg[`SSL_AUTO];
  assign hside.deep      = (mode_reg == pm_deep);

  ssl_state_map #(.HIGH_SIDE(1'b0)) u_low_map  (.side(lside.map));
  ssl_state_map #(.HIGH_SIDE(1'b1)) u_high_map (.side(hside.map));

  // Settling delays per side and the wakeup delay
  ssl_settle_timer #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_low_settle (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (low_start),
    .slow_sel (!lctl_next[`SSL_SUP_FP]),   // [RQ16]
    .busy     (low_busy)
  );
  ssl_settle_timer #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_high_settle (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (high_start),
    .slow_sel (!hctl_next[`SSL_SUP_FP]),   // [RQ16]
    .busy     (high_busy)
  );
  ssl_settle_timer #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_wake (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (wake_start),
    .slow_sel (wake_slow),
    .busy     (wake_busy)
  );

  // Comparator events, masked while settling or while the unit is off
  logic low_ev, lsup_ev, lmon_ev, hovp_ev;
  assign lsup_ev = lsup_s && (lside.sup_state != ssl_off) && !low_busy;   // [RQ16]
  assign lmon_ev = lmon_s && (lside.mon_state != ssl_off) && !low_busy;   // [RQ16]
  assign hovp_ev = hmon_s && (hside.mon_state != ssl_off) && !high_busy
                   && hctl_reg[`SSL_SIDE_OPT];                            // [RQ13] [RQ14]
  assign low_ev  = lsup_ev || lmon_ev;
  assign ev_set  = {hovp_ev, lmon_ev, lsup_ev};

  // APB decode, register writes and read data
  always_comb begin
    rsel           = word_sel(paddr);
    wsel           = rsel;
    wr             = psel && penable && pready_reg && pwrite;
    hctl_next      = hctl_reg;
    lctl_next      = lctl_reg;
    ev_next        = ev_reg | ev_set;
    mode_ctl_next  = mode_ctl_reg;
    key_armed_next = key_armed_reg;
    prolong_next   = prolong_reg;
    enter_req      = 1'b0;
    low_start      = 1'b0;
    high_start     = 1'b0;
    pready_next    = psel && !penable;
    pslverr_next   = psel && !penable && (rsel == 6'h00);
    prdata_next    = prdata_reg;
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      unique case (1'b1)
        rsel[0]: prdata_next[`SSL_CTL_W-1:0] = hctl_reg;
        rsel[1]: prdata_next[`SSL_CTL_W-1:0] = lctl_reg;
        rsel[2]: prdata_next[4:0] = {ev_reg, high_busy, low_busy};
        rsel[3]: prdata_next[8:0] = {wake_slow, mode_reg, 1'b0, mode_ctl_reg, 1'b0};
        rsel[4]: prdata_next[0] = key_armed_reg;
        rsel[5]: prdata_next[`SSL_PROL_BIT] = prolong_reg;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      if (wsel != 6'h00) begin
        key_armed_next = 1'b0;
      end
      unique case (1'b1)
        wsel[0]: begin
          hctl_next  = pwdata[`SSL_CTL_W-1:0];
          high_start = 1'b1;                                              // [RQ17]
        end
        wsel[1]: begin
          lctl_next = pwdata[`SSL_CTL_W-1:0];
          low_start = 1'b1;                                               // [RQ17]
        end
        wsel[2]: ev_next = (ev_reg & ~pwdata[`SSL_FLG_HOVP:`SSL_FLG_LSUP]) | ev_set;
        wsel[3]: begin
          mode_ctl_next = pwdata[`SSL_MODE_AUTO:`SSL_MODE_DEEP];
          enter_req     = pwdata[`SSL_MODE_ENTER];                        // [RQ9]
        end
        wsel[4]: key_armed_next = (pwdata[15:0] == `SSL_PROL_KEY);
        wsel[5]: begin
          if (key_armed_reg) begin
            prolong_next = pwdata[`SSL_PROL_BIT];
          end
        end
        default: ;
      endcase
    end
    if (puc_s) begin
      key_armed_next = 1'b0;
    end
  end

  // Register file flops; of the two resets, only brown-out clears the prolongation enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hctl_reg      <= `SSL_HCTL_RST;
      lctl_reg      <= `SSL_LCTL_RST;
      ev_reg        <= 3'h0;
      mode_ctl_reg  <= `SSL_MODE_RST;
      key_armed_reg <= 1'b0;
      prolong_reg   <= 1'b0;                                              // [RQ12]
      prdata_reg    <= 32'h0000_0000;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      hctl_reg      <= hctl_next;
      lctl_reg      <= lctl_next;
      ev_reg        <= ev_next;
      mode_ctl_reg  <= mode_ctl_next;
      key_armed_reg <= key_armed_next;
      prolong_reg   <= prolong_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  // Power mode sequencer with a post-entry guard window
  always_comb begin
    mode_next      = mode_reg;
    guard_next     = (guard_reg != 7'h00) ? guard_reg - 1'b1 : guard_reg;
    irq_latch_next = irq_latch_reg;
    wake_start     = 1'b0;
    wake_slow_next = (lside.sup_en && !lside.sup_fp) || (lside.mon_en && !lside.mon_fp); // [RQ6] [RQ7]
    unique case (mode_reg)
      pm_active: begin
        if (enter_req || (isr_return && mode_ctl_reg[1])) begin          // [RQ9]
          if (mode_ctl_next[0]) begin                                     // Deep select of the same write counts
            mode_next  = pm_deep;
            guard_next = 7'(GUARD_CYC);
          end else begin
            mode_next = pm_light;
          end
        end
      end
      pm_light: begin
        if (irq_s) begin
          mode_next = pm_active;
        end
      end
      pm_deep: begin
        if (irq_s) begin
          irq_latch_next = 1'b1;                                          // [RQ10]
        end
        if ((irq_s || irq_latch_reg) && guard_reg == 7'h00) begin
          mode_next      = pm_wake;
          wake_start     = 1'b1;
          irq_latch_next = 1'b0;
        end
      end
      pm_wake: begin
        if (!wake_busy) begin
          mode_next = pm_active;                                          // [RQ6]
        end
      end
      default: mode_next = pm_active;
    endcase
    if (puc_s) begin
      mode_next      = pm_active;                                         // [RQ10]
      guard_next     = 7'h00;
      irq_latch_next = 1'b0;
      wake_start     = 1'b0;
    end
  end

  // Sequencer flops and registered outputs
  ssl_unit_t lsup_q, lmon_q, hsup_q, hmon_q;
  logic      wake_slow_reg, cpu_hold_reg, por_reg, irq_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg      <= pm_active;
      guard_reg     <= 7'h00;
      irq_latch_reg <= 1'b0;
      wake_slow_reg <= 1'b1;
      cpu_hold_reg  <= 1'b0;
      lsup_q        <= ssl_off;
      lmon_q        <= ssl_off;
      hsup_q        <= ssl_off;
      hmon_q        <= ssl_off;
      por_reg       <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      guard_reg     <= guard_next;
      irq_latch_reg <= irq_latch_next;
      wake_slow_reg <= wake_slow_next;
      cpu_hold_reg  <= (mode_next == pm_wake);
      lsup_q        <= lside.sup_state;
      lmon_q        <= lside.mon_state;
      hsup_q        <= hside.sup_state;
      hmon_q        <= hside.mon_state;
      por_reg       <= (low_ev && lctl_reg[`SSL_SIDE_OPT]) || hovp_ev;    // [RQ13] [RQ15]
      irq_reg       <= low_ev && !lctl_reg[`SSL_SIDE_OPT];                // [RQ15]
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign power_mode      = mode_reg;
  assign low_sup_state   = lsup_q;
  assign low_mon_state   = lmon_q;
  assign high_sup_state  = hsup_q;
  assign high_mon_state  = hmon_q;
  assign wake_slow       = wake_slow_reg;
  assign cpu_hold        = cpu_hold_reg;
  assign por_request     = por_reg;
  assign low_event_irq   = irq_reg;
  assign prolong_enable  = prolong_reg;
  assign low_delay_flag  = low_busy;
  assign high_delay_flag = high_busy;

  // Checks of the block's behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_low_sup_off;
    (!lside.sup_en && mode_reg != pm_deep) |=> (low_sup_state == ssl_off);
  endproperty
  a_low_sup_off: assert property (p_low_sup_off) else $error("low supervisor not off when disabled"); // [RQ1]

  property p_low_auto_deep;
    (lside.deep && lside.auto_ctrl && lside.sup_en && lside.sup_keep && lside.sup_fp) |-> lside.sup_state == ssl_norm;
  endproperty
  a_low_auto_deep: assert property (p_low_auto_deep) else $error("auto deep low supervisor not normal"); // [RQ2]

  property p_low_mon_auto;
    (lside.deep && lside.auto_ctrl && lside.mon_en && !lside.mon_fp) |-> lside.mon_state == ssl_off;
  endproperty
  a_low_mon_auto: assert property (p_low_mon_auto) else $error("auto deep low monitor not off"); // [RQ3]

  property p_high_mon_auto;
    (hside.deep && hside.auto_ctrl) |-> hside.mon_state == ssl_off;
  endproperty
  a_high_mon_auto: assert property (p_high_mon_auto) else $error("high monitor active in deep auto mode"); // [RQ14]

  property p_slow_wake_hold;
    ($rose(cpu_hold) && wake_slow) |-> cpu_hold [*8];
  endproperty
  a_slow_wake_hold: assert property (p_slow_wake_hold) else $error("slow wakeup ended too early"); // [RQ6]

  property p_settle_set;
    (wr && wsel[1]) |=> low_delay_flag;
  endproperty
  a_settle_set: assert property (p_settle_set) else $error("low delay flag not set on write"); // [RQ17]

  property p_settle_fast_end;
    ($rose(low_delay_flag) && lctl_reg[`SSL_SUP_FP]) |-> ##[249:251] !low_delay_flag;
  endproperty
  a_settle_fast_end: assert property (p_settle_fast_end) else $error("fast settling delay wrong length"); // [RQ16]

  property p_prolong_rise;
    $rose(prolong_enable) |-> $past(key_armed_reg) && $past(wr && wsel[5]);
  endproperty
  a_prolong_rise: assert property (p_prolong_rise) else $error("prolongation enabled without key"); // [RQ12]

  property p_puc_active;
    puc_s |=> (power_mode == pm_active);
  endproperty
  a_puc_active: assert property (p_puc_active) else $error("power-up-clear did not restore active mode"); // [RQ10]

  property p_ovp_por;
    hovp_ev |=> por_request;
  endproperty
  a_ovp_por: assert property (p_ovp_por) else $error("overvoltage trip without reset request"); // [RQ13]

  property p_low_irq;
    (low_ev && !lctl_reg[`SSL_SIDE_OPT]) |=> (low_event_irq && !por_request);
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low event did not raise interrupt"); // [RQ15]
endmodule : ssl_top
`default_nettype wire

// ---- testbench/supply_supervisor_lpm_control_tb.sv ----
// Self-checking bench of the supply supervisor block
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_lpm_control_tb;
  import ssl_pkg::*;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, wake_slow, cpu_hold, por_request, low_event_irq, prolong_enable, ldf, hdf, err;
  logic pucr = 0, irq = 0, lst = 0, lmt = 0, hmt = 0, isr = 0;
  logic [6:0] lc, hc;
  ssl_pmode_t power_mode;
  ssl_unit_t lss, lms, hss, hms;
  int error_cnt = 0, checked = 0;
  always #4 core_clk = ~core_clk;
  ssl_top #(.SLOW_CYC(300)) dut_u (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_up_clear_reset(pucr), .irq_pending(irq), .low_sup_trip(lst),
    .low_mon_trip(lmt), .high_mon_trip(hmt), .isr_return(isr), .power_mode(power_mode),
    .low_sup_state(lss), .low_mon_state(lms), .high_sup_state(hss), .high_mon_state(hms),
    .wake_slow(wake_slow), .cpu_hold(cpu_hold), .por_request(por_request),
    .low_event_irq(low_event_irq), .prolong_enable(prolong_enable), .low_delay_flag(ldf),
    .high_delay_flag(hdf));
  // Expected unit state from the control bits; keep is the supervisor keep bit
  function automatic logic [1:0] st(input logic en, fp, keep, auto, deep, mon, hi);
    if (!en) return 2'h0;
    if (!deep) return fp ? 2'h2 : 2'h1;
    if (auto) return (mon ? fp && !hi : keep && fp) ? 2'h1 : 2'h0;
    if (mon && hi && !fp && !keep) return 2'h0;
    return (mon || keep) ? (fp ? 2'h2 : 2'h1) : 2'h0;
  endfunction : st
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      error_cnt++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask : apb
  // Bounded wait: k=0 both settling flags clear, k=1 back in active mode
  task automatic wt(input int k);
    for (int n = 0; n < 3000; n++) begin
      @(posedge core_clk);
      if (k ? power_mode === pm_active : {ldf, hdf} === 2'b00) return;
    end
    error_cnt++;
    conclude();
  endtask : wt
  // Compare all four unit states with the model
  task automatic states(input logic dp);
    chk("low_sup", lss, st(lc[0], lc[2], lc[1], lc[5], dp, 0, 0));
    chk("low_mon", lms, st(lc[3], lc[4], lc[1], lc[5], dp, 1, 0));
    chk("high_sup", hss, st(hc[0], hc[2], hc[1], hc[5], dp, 0, 1));
    chk("high_mon", hms, st(hc[3], hc[4], hc[1], hc[5], dp, 1, 1));
  endtask : states
  initial begin
    void'($urandom(94288));
    repeat (6) @(posedge core_clk);
    rst <= 0;
    repeat (2) @(posedge core_clk);
    lc = 7'h01;
    hc = 7'h01;
    states(0);
    chk("wake_slow", wake_slow, 1);
    apb(0, 12'hFFC, 0);
    chk("unmapped_err", err, 1);
    chk("unmapped_rd", rd, 0);
    // Random settings, deep entry by request or routine return, wakeup
    for (int k = 0; k < 8; k++) begin
      lc = 7'($urandom);
      hc = 7'($urandom);
      apb(1, 12'h004, lc);
      chk("low_delay", ldf, 1);
      apb(1, 12'h000, hc);
      wt(0);
      states(0);
      chk("wake_slow", wake_slow, lc[0] & !lc[2] | lc[3] & !lc[4]);
      apb(1, 12'h00C, k[0] ? 32'h6 : 32'h3);
      if (k[0]) isr <= 1;
      @(posedge core_clk);
      isr <= 0;
      repeat (3) @(posedge core_clk);
      chk("mode", power_mode, pm_deep);
      states(1);
      irq <= 1;
      wt(1);
      irq <= 0;
      chk("cpu_hold", cpu_hold, 0);
    end
    $display("test states done");
    // Reset or interrupt routing of low supervisor and high monitor events
    for (int i = 0; i < 3; i++) begin
      apb(1, i == 2 ? 12'h000 : 12'h004, i == 0 ? 32'h41 : i == 1 ? 32'h01 : 32'h49);
      wt(0);
      if (i == 2) hmt <= 1;
      else lst <= 1;
      repeat (6) @(posedge core_clk);
      chk("por", por_request, i != 1);
      chk("irq", low_event_irq, i == 1);
      apb(0, 12'h008, 0);
      chk("flags", rd[4:0], i == 2 ? 5'h10 : 5'h04);
      lst <= 0;
      hmt <= 0;
      repeat (3) @(posedge core_clk);
      apb(1, 12'h008, 32'h1C);
    end
    // Light mode entry by request and wakeup by interrupt
    apb(1, 12'h00C, 32'h1);
    chk("light", power_mode, pm_light);
    irq <= 1;
    wt(1);
    irq <= 0;
    // Prolongation needs the key; power-up clear wakes; brown-out clears it
    apb(1, 12'h448, 32'h800);
    chk("prolong", prolong_enable, 0);
    apb(1, 12'h440, 32'h9602);
    apb(1, 12'h448, 32'h800);
    chk("prolong", prolong_enable, 1);
    apb(1, 12'h00C, 32'h3);
    pucr <= 1;
    repeat (6) @(posedge core_clk);
    pucr <= 0;
    repeat (4) @(posedge core_clk);
    chk("puc_mode", {power_mode, prolong_enable}, {pm_active, 1'b1});
    rst <= 1;
    @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    chk("prolong", prolong_enable, 0);
    $display("test events done");
    conclude();
  end
endmodule : supply_supervisor_lpm_control_tb
`default_nettype wire
